// file: lcd_port_pkg.sv
package lcd_port_pkg;
  // apb register map (byte addresses, one aligned word each)
  localparam int APB_AW = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00; // port enable
  localparam logic [7:0] STATUS_OFS = 8'h04; // live block state
  localparam logic [7:0] MEMSEL_OFS = 8'h08; // display memory word index
  localparam logic [7:0] MEMDATA_OFS = 8'h0c; // display memory word at index
  // status field positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_MODE_POS = 1;
  localparam int STAT_STEP_POS = 6;
  localparam int STAT_PTR_POS = 8;
  localparam int STAT_DISP_POS = 15;
  // values after reset
  localparam logic CTRL_PORT_EN_RST = 1'b1;
  localparam logic [1:0] STEP_RST = 2'b00;
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic DISP_ON_RST = 1'b0;
  // display memory: two banks of 40 bytes
  localparam int MEM_WORDS = 80;
  localparam logic [6:0] MEM_WORDS7 = 7'h50;
  localparam logic [5:0] BANK_ROWS = 6'h28;
  localparam logic [6:0] BANK_ROWS7 = 7'h28;
  // pointer step codes
  localparam logic [1:0] STEP_INC = 2'b00;
  localparam logic [1:0] STEP_DEC = 2'b01;
  // command codes
  localparam logic [5:0] CMD_READ_TOP = 6'h18; // set_read_mode_cmd, low 2 bits step
  localparam logic [5:0] CMD_WRITE_TOP = 6'h19; // set_write_mode_cmd
  localparam logic [5:0] CMD_OR_TOP = 6'h1a; // set_or_mode_cmd
  localparam logic [5:0] CMD_AND_TOP = 6'h1b; // set_and_mode_cmd
  localparam logic [7:0] CMD_GLYPH = 8'h72; // set_glyph_mode_cmd
  localparam logic [2:0] CMD_MEMORY_BIT_SET_CMD_TOP = 3'h2; // memory_bit_set_cmd
  localparam logic [2:0] CMD_BCLR_TOP = 3'h1; // memory_bit_clear_cmd
  localparam logic [7:0] CMD_DISPLAY_BLANK_CMD = 8'h08; // display_blank_cmd
  localparam logic [7:0] CMD_DISP_ON = 8'h09;
  // serial and glyph counts
  localparam logic [2:0] CNT_LAST = 3'h7;
  localparam logic [2:0] GLYPH_LAST_COL = 3'h4;
  localparam logic [5:0] GLYPH_STEP = 6'h05;
  localparam logic [6:0] GLYPH_ALL_LIT = 7'h7f;
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EXEC = 5'b00010,
    ST_GLYPH = 5'b00100,
    ST_RELOAD = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;
  // data modes
  typedef enum logic [4:0] {
    MD_READ = 5'b00001,
    MD_WRITE = 5'b00010,
    MD_AND = 5'b00100,
    MD_OR = 5'b01000,
    MD_GLYPH = 5'b10000
  } mode_t;
endpackage

// file: lcd_serial_port.sv
module lcd_serial_port
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // serial link pins
  input wire logic SCK_I,
  input wire logic SI_I,
  input wire logic CD_I,
  output logic SO_BUSY_O,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [lcd_port_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O
);
  import lcd_port_pkg::*;

  // whole block state in one record
  typedef struct packed {
    state_t st; // sequencer
    mode_t mode; // current data mode
    logic [1:0] step; // step code of the current mode
    logic bank; // pointer bank flag
    logic [5:0] addr; // pointer counter
    logic disp_on; // display enable flag
    logic port_en; // software gate on the serial port
    logic [6:0] memsel; // apb memory window index
    logic sck_s1, sck_s2, sck_s3; // shift clock synchroniser and edge history
    logic si_s1, si_s2; // serial input synchroniser
    logic cd_s1, cd_s2; // select line synchroniser
    logic in_bit; // bit sampled at the last rising edge
    logic [7:0] sr; // serial register
    logic [2:0] cnt; // shift clock counter
    logic busy; // byte being processed
    logic cd_lat; // select level latched with the byte
    logic [7:0] byte_q; // completed byte
    logic [2:0] gcol; // glyph column being written
    logic so; // serial out / busy pin
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [MEM_WORDS-1:0][7:0] mem; // display memory, bank 0 then bank 1
  } core_t;

  core_t q, d;
  logic rise, fall; // synchronised shift clock edges
  logic [6:0] cur_idx; // memory word under the pointer
  logic cur_ok; // pointer lands on real memory
  logic [7:0] cur_mem; // memory byte under the pointer
  logic [5:0] g_addr; // glyph column address
  logic [31:0] rd_word; // apb read value
  state_t after_cmd; // where a command goes next
  logic [7:0] bit_mask; // bit set/clear mask

  // pointer stepping; the forbidden code just holds
  function automatic logic [5:0] step_addr(input logic [5:0] a, input logic [1:0] code);
    case (code)
      STEP_INC: step_addr = a + 6'h01;
      STEP_DEC: step_addr = a - 6'h01;
      default: step_addr = a;
    endcase
  endfunction

  // bank and counter to flat word index
  function automatic logic [6:0] mem_idx(input logic b, input logic [5:0] a);
    mem_idx = {1'b0, a} + (b ? BANK_ROWS7 : 7'h00);
  endfunction

  // glyph column; a synthetic dot pattern stands in for the font contents
  function automatic logic [6:0] glyph_col(input logic [6:0] code, input logic [2:0] col);
    logic [13:0] twice;
    twice = {code, code};
    if (code == GLYPH_ALL_LIT || code == 7'h00)
      glyph_col = GLYPH_ALL_LIT;
    else
      glyph_col = 7'(twice >> col);
  endfunction

  // helpers shared by the sequencer and the checks
  assign rise = q.sck_s2 & ~q.sck_s3;
  assign fall = ~q.sck_s2 & q.sck_s3;
  assign cur_idx = mem_idx(q.bank, q.addr);
  assign cur_ok = (q.addr < BANK_ROWS);
  assign cur_mem = cur_ok ? q.mem[cur_idx] : 8'h00;
  assign g_addr = q.addr + {3'h0, q.gcol};
  assign after_cmd = (q.mode == MD_READ) ? ST_RELOAD : ST_DONE;
  assign bit_mask = 8'h01 << q.byte_q[4:2];

  // apb read mux
  always_comb
  begin
    rd_word = 32'h0;
    case (PADDR_I)
      CTRL_OFS: rd_word[0] = q.port_en;
      STATUS_OFS:
      begin
        rd_word[STAT_BUSY_POS] = q.busy;
        rd_word[STAT_MODE_POS +: 5] = q.mode;
        rd_word[STAT_STEP_POS +: 2] = q.step;
        rd_word[STAT_PTR_POS +: 7] = {q.bank, q.addr};
        rd_word[STAT_DISP_POS] = q.disp_on;
      end
      MEMSEL_OFS: rd_word[6:0] = q.memsel;
      MEMDATA_OFS: rd_word[7:0] = (q.memsel < MEM_WORDS7) ? q.mem[q.memsel] : 8'h00;
      default: rd_word = 32'h0;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    d = q;
    // two flops on every pin, a third on the shift clock for edges; the first is read only by the second
    d.sck_s1 = SCK_I;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.si_s1 = SI_I;
    d.si_s2 = q.si_s1;
    d.cd_s1 = CD_I;
    d.cd_s2 = q.cd_s1;
    case (q.st)
      ST_IDLE:
      begin
        // edges are ignored while busy, so stray host clocks do nothing
        if (q.port_en && rise)
        begin
          d.in_bit = q.si_s2;
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == CNT_LAST)
          begin
            d.byte_q = {q.sr[6:0], q.si_s2};
            d.cd_lat = q.cd_s2;
            d.busy = 1'b1;
            d.st = ST_EXEC;
          end
        end
        else if (q.port_en && fall)
          d.sr = {q.sr[6:0], q.in_bit};
      end
      ST_EXEC:
      begin
        d.st = ST_DONE;
        if (!q.cd_lat)
        begin
          // data byte in the current mode
          case (q.mode)
            MD_READ:
              if (cur_ok)
                d.sr = cur_mem;
            MD_WRITE:
              if (cur_ok)
                d.mem[cur_idx] = q.byte_q;
            MD_AND:
              if (cur_ok)
                d.mem[cur_idx] = cur_mem & q.byte_q;
            MD_OR:
              if (cur_ok)
                d.mem[cur_idx] = cur_mem | q.byte_q;
            MD_GLYPH:
            begin
              d.gcol = 3'h0;
              d.st = ST_GLYPH;
            end
            default: d.st = ST_DONE;
          endcase
          if (q.mode != MD_GLYPH) // glyph steps by five on its own
            d.addr = step_addr(q.addr, q.step);
        end
        else if (q.byte_q[7])
        begin
          // pointer load; bit 6 is the bank flag
          {d.bank, d.addr} = q.byte_q[6:0];
          d.st = after_cmd;
        end
        else if (q.byte_q[7:2] == CMD_READ_TOP)
        begin
          d.mode = MD_READ;
          d.step = q.byte_q[1:0];
          d.st = ST_RELOAD;
        end
        else if (q.byte_q[7:2] == CMD_WRITE_TOP)
        begin
          d.mode = MD_WRITE;
          d.step = q.byte_q[1:0];
        end
        else if (q.byte_q[7:2] == CMD_AND_TOP)
        begin
          d.mode = MD_AND;
          d.step = q.byte_q[1:0];
        end
        else if (q.byte_q[7:2] == CMD_OR_TOP)
        begin
          d.mode = MD_OR;
          d.step = q.byte_q[1:0];
        end
        else if (q.byte_q == CMD_GLYPH)
          d.mode = MD_GLYPH;
        else if (q.byte_q[7:5] == CMD_MEMORY_BIT_SET_CMD_TOP)
        begin
          if (cur_ok)
            d.mem[cur_idx] = cur_mem | bit_mask;
          d.addr = step_addr(q.addr, q.byte_q[1:0]);
          d.st = after_cmd;
        end
        else if (q.byte_q[7:5] == CMD_BCLR_TOP)
        begin
          if (cur_ok)
            d.mem[cur_idx] = cur_mem & ~bit_mask;
          d.addr = step_addr(q.addr, q.byte_q[1:0]);
          d.st = after_cmd;
        end
        else
        begin
          // display and timing commands; only the display flag lives here
          if (q.byte_q == CMD_DISPLAY_BLANK_CMD)
            d.disp_on = 1'b0;
          else if (q.byte_q == CMD_DISP_ON)
            d.disp_on = 1'b1;
          d.st = after_cmd;
        end
      end
      ST_GLYPH:
      begin
        // one column per cycle; bit 7 keeps its old value
        if (g_addr < BANK_ROWS)
          d.mem[mem_idx(q.bank, g_addr)][6:0] = glyph_col(q.byte_q[6:0], q.gcol);
        if (q.gcol == GLYPH_LAST_COL)
        begin
          d.addr = q.addr + GLYPH_STEP;
          d.st = ST_DONE;
        end
        else
          d.gcol = q.gcol + 3'h1;
      end
      ST_RELOAD: // a pending read byte is replaced here
      begin
        if (cur_ok)
          d.sr = cur_mem;
        d.addr = step_addr(q.addr, q.step);
        d.st = ST_DONE;
      end
      ST_DONE:
      begin
        // busy holds until the clock is seen low, so the last fall shifts no fresh byte
        if (!q.sck_s2 && !q.sck_s3)
        begin
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
        d.busy = 1'b0;
      end
    endcase
    // pin: busy low, else serial bit with select low, else high
    d.so = d.busy ? 1'b0 : (q.cd_s2 ? 1'b1 : d.sr[7]);
    // apb: one wait state, write lands on the completing edge
    d.pready = 1'b0;
    if (PSEL_I && PENABLE_I && !q.pready)
    begin
      d.pready = 1'b1;
      d.prdata = PWRITE_I ? 32'h0 : rd_word;
      d.pslverr = !(PADDR_I == CTRL_OFS || PADDR_I == STATUS_OFS ||
                    PADDR_I == MEMSEL_OFS || PADDR_I == MEMDATA_OFS);
    end
    else if (PSEL_I && PENABLE_I && q.pready && PWRITE_I && PSTRB_I[0])
    begin
      if (PADDR_I == CTRL_OFS)
        d.port_en = PWDATA_I[0];
      else if (PADDR_I == MEMSEL_OFS)
        d.memsel = PWDATA_I[6:0];
    end
  end

  // state register; constants only under reset
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.mode <= MD_WRITE;
      q.step <= STEP_RST;
      {q.bank, q.addr} <= PTR_RST;
      q.disp_on <= DISP_ON_RST;
      q.port_en <= CTRL_PORT_EN_RST;
      q.so <= 1'b1;
      {q.cd_s1, q.cd_s2} <= 2'b11; // select idles high: no false low on the pin after reset
    end
    else
      q <= d;
  end

  // outputs straight from flops
  assign SO_BUSY_O = q.so;
  assign PREADY_O = q.pready;
  assign PRDATA_O = q.prdata;
  assign PSLVERR_O = q.pslverr;

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  logic ex_data;
  assign ex_data = (q.st == ST_EXEC) && !q.cd_lat;

  property p_pointer_load_cmd;
    (q.st == ST_EXEC) && q.cd_lat && q.byte_q[7] |=> {q.bank, q.addr} == $past(q.byte_q[6:0]);
  endproperty
  a_pointer_load_cmd: assert property (p_pointer_load_cmd) else $error("pointer load mismatch");
  property p_cnt;
    (q.st == ST_IDLE) && q.port_en && rise |=> q.cnt == $past(q.cnt) + 3'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("shift counter did not step");
  property p_busy_go;
    (q.st == ST_IDLE) && q.port_en && rise && q.cnt == CNT_LAST
      |=> q.busy && !SO_BUSY_O && q.cd_lat == $past(q.cd_s2);
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("no busy after byte");
  property p_so_busy;
    q.busy |-> !SO_BUSY_O;
  endproperty
  a_so_busy: assert property (p_so_busy) else $error("pin high while busy");
  property p_write;
    ex_data && q.mode == MD_WRITE && cur_ok |=> q.mem[$past(cur_idx)] == $past(q.byte_q)
      && q.addr == step_addr($past(q.addr), $past(q.step));
  endproperty
  a_write: assert property (p_write) else $error("write mode store wrong");
  property p_and;
    ex_data && q.mode == MD_AND && cur_ok |=> q.mem[$past(cur_idx)] == ($past(cur_mem) & $past(q.byte_q));
  endproperty
  a_and: assert property (p_and) else $error("and mode result wrong");
  property p_or;
    ex_data && q.mode == MD_OR && cur_ok |=> q.mem[$past(cur_idx)] == ($past(cur_mem) | $past(q.byte_q));
  endproperty
  a_or: assert property (p_or) else $error("or mode result wrong");
  property p_range;
    ex_data && !cur_ok && q.mode != MD_GLYPH |=> q.mem == $past(q.mem);
  endproperty
  a_range: assert property (p_range) else $error("memory touched out of range");
  property p_glyph;
    ex_data && q.mode == MD_GLYPH |-> ##6 q.addr == $past(q.addr, 6) + GLYPH_STEP;
  endproperty
  a_glyph: assert property (p_glyph) else $error("glyph step not five");
  property p_lit;
    ex_data && q.mode == MD_GLYPH && cur_ok && q.byte_q[6:0] == 7'h00
      |-> ##2 q.mem[$past(cur_idx, 2)][6:0] == GLYPH_ALL_LIT;
  endproperty
  a_lit: assert property (p_lit) else $error("blank code not fully lit");
  property p_read;
    ex_data && q.mode == MD_READ && cur_ok |=> q.sr == $past(cur_mem);
  endproperty
  a_read: assert property (p_read) else $error("read reload wrong");
  property p_shift;
    (q.st == ST_IDLE) && q.port_en && fall |=> q.sr == {$past(q.sr[6:0]), $past(q.in_bit)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift on fall wrong");
  property p_bound;
    q.st == ST_EXEC |-> ##[1:7] q.st == ST_DONE;
  endproperty
  a_bound: assert property (p_bound) else $error("processing too long");
  c_write: cover property (ex_data && q.mode == MD_WRITE && cur_ok);
  c_glyph: cover property (q.st == ST_GLYPH && q.gcol == GLYPH_LAST_COL);
  c_read: cover property (ex_data && q.mode == MD_READ);
  c_cmd_reload: cover property ((q.st == ST_EXEC) && q.cd_lat ##1 q.st == ST_RELOAD);
endmodule // lcd_serial_port

// file: lcd_host_model.sv
module lcd_host_model
(
  // device clock, paces the link
  input wire logic clk_i,
  // serial link pins
  output logic sck_o,
  output logic si_o,
  output logic cd_o,
  input wire logic so_busy_i
);
  timeunit 1ns;
  timeprecision 1ps;

  int errs = 0; // handshake waits that ran out

  // link clock stands low between frames
  initial
  begin
    sck_o = 1'b0;
    si_o = 1'b0;
    cd_o = 1'b1;
  end

  // bounded wait for a level on the busy pin, sampled mid-cycle to avoid races
  task automatic wait_so(input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge clk_i);
    while (so_busy_i !== lvl && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    if (so_busy_i !== lvl)
      errs++;
  endtask

  // one byte each way, msb first; low half 5 clocks so output has settled
  task automatic xfer(input logic cd, input logic [7:0] tx, output logic [7:0] rx);
    wait_so(1'b1, 80);
    @(posedge clk_i);
    cd_o <= cd;
    for (int i = 7; i >= 0; i--)
    begin
      si_o <= tx[i];
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      rx[i] = so_busy_i;
      @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    // a byte ignored with the port off raises no busy, so data bytes wait a fixed time
    if (cd)
      wait_so(1'b0, 12);
    else
      repeat (6) @(posedge clk_i);
    @(posedge clk_i);
    cd_o <= 1'b1;
    si_o <= ~si_o; // released line does not keep its last value
    wait_so(1'b1, 80);
  endtask
endmodule // lcd_host_model

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_port_pkg::*;

  // clock, reset and apb
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf; // only tied input
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  // link pins
  logic sck;
  logic si;
  logic cd;
  logic so;
  // bookkeeping and expectation model
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] lfsr = 32'h02e4;
  logic [7:0] mem_m [MEM_WORDS];
  logic [6:0] ptr_m = PTR_RST;
  logic [1:0] step_m = STEP_RST;
  int mode_m = 1; // 0 read 1 write 2 and 3 or 4 glyph
  logic disp_m = DISP_ON_RST;
  logic [7:0] rd_m = 8'h00;
  logic [7:0] rx;
  logic [31:0] rv;
  logic er;

  always #12.5 clk = ~clk;

  lcd_serial_port i_lcd_serial_port (.CLOCK_I(clk), .RESET_I(rst), .SCK_I(sck), .SI_I(si),
    .CD_I(cd), .SO_BUSY_O(so), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr));
  lcd_host_model i_lcd_host_model (.clk_i(clk), .sck_o(sck), .si_o(si), .cd_o(cd),
    .so_busy_i(so));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr[7:0];
  endfunction

  // counter steps inside its bank; code 10 is held
  function automatic logic [6:0] nxt(input logic [6:0] p, input logic [1:0] c);
    if (c == STEP_INC)
      return {p[6], p[5:0] + 6'h01};
    if (c == STEP_DEC)
      return {p[6], p[5:0] - 6'h01};
    return p;
  endfunction

  // memory word of a pointer, -1 in the hole above 39
  function automatic int idx(input logic [6:0] p);
    return (p[5:0] < BANK_ROWS) ? int'(p[6]) * 40 + int'(p[5:0]) : -1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; pready sampled at rising edges, answer taken at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40)
    begin
      chk("pready", 1, 0);
      results();
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_all();
    apb(1'b0, STATUS_OFS, 0);
    chk("status", {16'h0, disp_m, ptr_m, step_m, 5'(1 << mode_m), 1'b0}, rv);
    for (int i = 0; i < MEM_WORDS; i++)
    begin
      apb(1'b1, MEMSEL_OFS, i);
      apb(1'b0, MEMDATA_OFS, 0);
      chk("memory", {24'h0, mem_m[i]}, rv);
    end
  endtask

  task automatic xf(input logic c, input logic [7:0] t);
    i_lcd_host_model.xfer(c, t, rx);
    if (i_lcd_host_model.errs != 0)
    begin
      chk("busy handshake", 0, i_lcd_host_model.errs);
      results();
    end
  endtask

  // serial register refill then read step
  task automatic reload();
    if (idx(ptr_m) >= 0)
      rd_m = mem_m[idx(ptr_m)];
    ptr_m = nxt(ptr_m, step_m);
  endtask

  task automatic cmd(input logic [7:0] c);
    xf(1'b1, c);
    if (c[7])
      ptr_m = c[6:0];
    if (c[7:4] == 4'h6)
    begin
      step_m = c[1:0];
      case (c[7:2])
        CMD_READ_TOP: mode_m = 0;
        CMD_WRITE_TOP: mode_m = 1;
        CMD_AND_TOP: mode_m = 2;
        default: mode_m = 3;
      endcase
    end
    if (c == CMD_GLYPH)
      mode_m = 4;
    if (c == CMD_DISP_ON || c == CMD_DISPLAY_BLANK_CMD)
      disp_m = c[0];
    if (c[7:5] == CMD_MEMORY_BIT_SET_CMD_TOP || c[7:5] == CMD_BCLR_TOP)
    begin
      if (idx(ptr_m) >= 0)
        mem_m[idx(ptr_m)][c[4:2]] = c[6];
      ptr_m = nxt(ptr_m, c[1:0]);
    end
    if (mode_m == 0)
      reload();
  endtask

  task automatic dat(input logic [7:0] b);
    int i;
    i = idx(ptr_m);
    xf(1'b0, b);
    if (mode_m == 0)
    begin
      chk("read byte", rd_m, rx);
      reload();
    end
    else if (mode_m == 4)
      // only codes that light every dot; bit 7 of each word is kept
      for (int k = 0; k < 5; k++)
      begin
        if (idx(ptr_m) >= 0)
          mem_m[idx(ptr_m)][6:0] = GLYPH_ALL_LIT;
        ptr_m = nxt(ptr_m, STEP_INC);
      end
    else
    begin
      if (i >= 0)
        mem_m[i] = mode_m == 1 ? b : mode_m == 2 ? mem_m[i] & b : mem_m[i] | b;
      ptr_m = nxt(ptr_m, step_m);
    end
  endtask

  initial
  begin
    for (int i = 0; i < MEM_WORDS; i++)
      mem_m[i] = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // reset values, refused addresses
    apb(1'b0, CTRL_OFS, 0);
    chk("ctrl", 32'h1, rv);
    apb(1'b0, 8'h10, 0);
    chk("unmapped error", 1, er);
    apb(1'b1, 8'h06, 32'h0);
    chk("unaligned error", 1, er);
    check_all();
    // write across the end of bank 0 into the hole
    cmd({CMD_WRITE_TOP, STEP_INC});
    cmd(8'ha6);
    repeat (4) dat(rnd());
    // decrement from bank 1 word 0 wraps to 63
    cmd({CMD_WRITE_TOP, STEP_DEC});
    cmd(8'hc0);
    repeat (2) dat(rnd());
    check_all();
    // and with hold, or with the forbidden code
    cmd(8'ha6);
    cmd({CMD_AND_TOP, 2'b11});
    dat(rnd());
    cmd({CMD_OR_TOP, 2'b10});
    dat(rnd());
    // glyphs over preset bytes
    cmd({CMD_WRITE_TOP, STEP_INC});
    cmd(8'hc5);
    repeat (10) dat(rnd() | 8'h80);
    cmd(8'hc5);
    cmd(CMD_GLYPH);
    dat(8'h7f);
    dat(8'h80);
    // read back, a command discards the loaded byte, then read again
    cmd(CMD_DISP_ON);
    cmd(8'hc5);
    cmd({CMD_READ_TOP, STEP_INC});
    check_all();
    repeat (3) dat(8'h00);
    cmd(CMD_DISPLAY_BLANK_CMD);
    dat(8'h00);
    // bit commands step by their own code, then reload
    cmd(8'h80);
    cmd({CMD_MEMORY_BIT_SET_CMD_TOP, 3'h3, STEP_DEC});
    repeat (2) dat(8'h00);
    cmd(8'hcb);
    cmd({CMD_BCLR_TOP, 3'h6, 2'b11});
    dat(8'h00);
    cmd({CMD_WRITE_TOP, STEP_DEC});
    dat(rnd());
    // with the port off the link is ignored
    apb(1'b1, CTRL_OFS, 32'h0);
    xf(1'b0, 8'h55);
    apb(1'b1, CTRL_OFS, 32'h1);
    check_all();
    results();
  end
endmodule // tb_top
